// ---- logic/ppo_options.sv ----
// positioning option word, shaft revolution array and feed constant divider
// Notes on behaviour
// - sub-entry 0 of revolutions array reads 8-bit feedback count, set by FEEDBACKS (four by default).
// - sub-entries 1..4 hold 32-bit shaft revolutions; entry 1 is sensorless feedback.
// - feed constant of feedback n is feed divided by its revolution count.
// - 16-bit read/write option word, reset 0001h, steers profile position moves.
// - relative base field only matters when control word bit 6 is set.
// - base 00 previous target (or zero), 01 ramp output, 10 actual, 11 reserved.
// - with release active, device clears new-setpoint bit 4, then acknowledge bit 12.
// - release 00 external, 01 on target reached, 10 as soon as possible, 11 reserved.
// - rotary 00 acts linear, wraps preset at range limits, allows multi-turn moves.
// - rotary 01 only negative via minimum, 10 only positive via maximum.
// - rotary 11 shortest path, positive when difference is under half a turn.
`timescale 1ns/100ps
module ppo_options
   import ppo_pkg::*;
#(
   parameter int FEEDBACKS = 4
) (
   input wire logic core_clk,
   input wire logic rst,
   // object dictionary access
   input wire logic od_wr,
   input wire logic od_rd,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_subindex,
   input wire logic [31:0] od_wdata,
   output logic [31:0] od_rdata,
   output logic od_ack,
   output logic od_err,
   // feed constant request
   input wire logic feed_start,
   input wire logic [1:0] feed_sel,
   input wire logic [31:0] feed_value,
   output logic [31:0] feed_constant,
   output logic feed_done,
   output logic feed_div_zero,
   // move planning
   input wire logic [15:0] control_word,
   input wire logic [15:0] status_word,
   input wire logic plan_req,
   input wire ppo_pos_t pos_in,
   input wire logic target_reached,
   output ppo_plan_t plan_out,
   output logic plan_valid,
   output logic clear_new_setpoint,
   output logic clear_setpoint_ack,
   output ppo_opt_t opt_word
);
   typedef enum logic {DIV_IDLE, DIV_RUN} ppo_div_state_t;

   // ==================================================
   // register file
   logic [31:0] shaft_rev_reg [FEEDBACKS];
   logic [31:0] shaft_rev_next [FEEDBACKS];
   ppo_opt_t opt_reg, opt_next;
   logic [31:0] rdata_reg, rdata_next;
   logic ack_reg, ack_next;
   logic err_reg, err_next;
   logic sub_hit;
   logic [7:0] sub_idx;

   always_comb begin
      sub_idx = od_subindex - PPO_SUB_FIRST;
      sub_hit = (od_subindex >= PPO_SUB_FIRST) && (sub_idx < 8'(FEEDBACKS));
      shaft_rev_next = shaft_rev_reg;
      opt_next = opt_reg;
      rdata_next = rdata_reg;
      ack_next = 1'b0;
      err_next = 1'b0;
      if (od_wr) begin
         if (od_index == PPO_IDX_SHAFT_REV && sub_hit) begin
            shaft_rev_next[sub_idx[1:0]] = od_wdata;
            ack_next = 1'b1;
         end else if (od_index == PPO_IDX_POS_OPT && od_subindex == PPO_SUB_COUNT) begin
            opt_next = ppo_opt_t'(od_wdata[15:0]);
            ack_next = 1'b1;
         end else begin
            // covers the read-only count entry as well
            err_next = 1'b1;
         end
      end else if (od_rd) begin
         ack_next = 1'b1;
         if (od_index == PPO_IDX_SHAFT_REV && od_subindex == PPO_SUB_COUNT) begin
            rdata_next = {24'h00_0000, 8'(FEEDBACKS)};
         end else if (od_index == PPO_IDX_SHAFT_REV && sub_hit) begin
            rdata_next = shaft_rev_reg[sub_idx[1:0]];
         end else if (od_index == PPO_IDX_POS_OPT && od_subindex == PPO_SUB_COUNT) begin
            rdata_next = {16'h0000, opt_reg};
         end else begin
            rdata_next = 32'h0000_0000;
            ack_next = 1'b0;
            err_next = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < FEEDBACKS; i++) begin
            shaft_rev_reg[i] <= PPO_SHAFT_REV_RESET;
         end
         opt_reg <= ppo_opt_t'(PPO_POS_OPT_RESET);
         rdata_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         shaft_rev_reg <= shaft_rev_next;
         opt_reg <= opt_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         err_reg <= err_next;
      end
   end

   // ==================================================
   // feed constant divider
   // bit-serial to keep the area small; one answer every 33 cycles for a nonzero divisor
   ppo_div_state_t div_state_reg, div_state_next;
   logic [32:0] rem_reg, rem_next;
   logic [31:0] quo_reg, quo_next;
   logic [31:0] divisor_reg, divisor_next;
   logic [5:0] step_reg, step_next;
   logic [31:0] fc_reg, fc_next;
   logic done_reg, done_next;
   logic dz_reg, dz_next;
   logic [32:0] rem_sh;

   always_comb begin
      div_state_next = div_state_reg;
      rem_next = rem_reg;
      quo_next = quo_reg;
      divisor_next = divisor_reg;
      step_next = step_reg;
      fc_next = fc_reg;
      done_next = 1'b0;
      dz_next = dz_reg;
      rem_sh = {rem_reg[31:0], quo_reg[31]};
      case (div_state_reg)
         DIV_IDLE: begin
            if (feed_start) begin
               divisor_next = shaft_rev_reg[feed_sel];
               quo_next = feed_value;
               rem_next = 33'h0_0000_0000;
               step_next = PPO_DIV_STEPS;
               if (shaft_rev_reg[feed_sel] == 32'h0000_0000) begin
                  // no meaningful constant; saturate and flag it
                  fc_next = 32'hFFFF_FFFF;
                  dz_next = 1'b1;
                  done_next = 1'b1;
               end else begin
                  dz_next = 1'b0;
                  div_state_next = DIV_RUN;
               end
            end
         end
         DIV_RUN: begin
            if (rem_sh >= {1'b0, divisor_reg}) begin
               rem_next = rem_sh - {1'b0, divisor_reg};
               quo_next = {quo_reg[30:0], 1'b1};
            end else begin
               rem_next = rem_sh;
               quo_next = {quo_reg[30:0], 1'b0};
            end
            step_next = step_reg - 6'h01;
            if (step_reg == 6'h01) begin
               fc_next = quo_next;
               done_next = 1'b1;
               div_state_next = DIV_IDLE;
            end
         end
         default: div_state_next = DIV_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_state_reg <= DIV_IDLE;
         rem_reg <= 33'h0_0000_0000;
         quo_reg <= 32'h0000_0000;
         divisor_reg <= 32'h0000_0000;
         step_reg <= 6'h00;
         fc_reg <= 32'h0000_0000;
         done_reg <= 1'b0;
         dz_reg <= 1'b0;
      end else begin
         div_state_reg <= div_state_next;
         rem_reg <= rem_next;
         quo_reg <= quo_next;
         divisor_reg <= divisor_next;
         step_reg <= step_next;
         fc_reg <= fc_next;
         done_reg <= done_next;
         dz_reg <= dz_next;
      end
   end

   // ==================================================
   // move planning and setpoint release
   ppo_plan_t plan_reg, plan_next;
   logic plan_valid_reg, plan_valid_next;
   logic signed [31:0] last_target_reg, last_target_next;
   logic nsp_clr_reg, nsp_clr_next;
   logic ack_clr_reg, ack_clr_next;
   logic signed [31:0] base, tgt, span, diff;

   always_comb begin
      plan_next = plan_reg;
      plan_valid_next = 1'b0;
      last_target_next = last_target_reg;
      base = 32'sh0000_0000;
      if (control_word[PPO_CW_RELATIVE]) begin
         case (opt_reg.relative_base_select)
            REL_PREV_TARGET: base = last_target_reg;
            REL_RAMP_OUTPUT: base = pos_in.ramp_out;
            REL_ACTUAL_POS: base = pos_in.actual;
            default: base = 32'sh0000_0000;
         endcase
      end
      tgt = base + pos_in.target;
      span = pos_in.range_max - pos_in.range_min + 32'sh0000_0001;
      diff = tgt - pos_in.actual;
      if (diff < 32'sh0000_0000) begin
         diff = diff + span;
      end
      if (plan_req) begin
         plan_valid_next = 1'b1;
         plan_next.abs_target = tgt;
         plan_next.allow_multi_turn = 1'b0;
         case (opt_reg.rotary_direction_option)
            ROT_LINEAR: begin
               // preset jumps to the other end once a limit is passed
               if (tgt > pos_in.range_max) begin
                  plan_next.abs_target = tgt - span;
               end else if (tgt < pos_in.range_min) begin
                  plan_next.abs_target = tgt + span;
               end
               plan_next.move_positive = tgt >= pos_in.actual;
               plan_next.via_limit = 1'b0;
               plan_next.allow_multi_turn = 1'b1;
            end
            ROT_NEG_ONLY: begin
               plan_next.move_positive = 1'b0;
               plan_next.via_limit = tgt > pos_in.actual;
            end
            ROT_POS_ONLY: begin
               plan_next.move_positive = 1'b1;
               plan_next.via_limit = tgt < pos_in.actual;
            end
            ROT_SHORTEST: begin
               plan_next.move_positive = diff < (span >>> 1);
               plan_next.via_limit = (diff < (span >>> 1)) ? (tgt < pos_in.actual) : (tgt > pos_in.actual);
            end
            default: plan_next.via_limit = 1'b0;
         endcase
         last_target_next = plan_next.abs_target;
      end
   end

   always_comb begin
      nsp_clr_next = 1'b0;
      // handshake bit 12 drops only after the device dropped bit 4
      ack_clr_next = nsp_clr_reg;
      if (control_word[PPO_CW_NEW_SETPOINT] && status_word[PPO_SW_SETPOINT_ACK] && !nsp_clr_reg) begin
         case (opt_reg.setpoint_release_option)
            RLS_ON_TARGET: nsp_clr_next = target_reached;
            RLS_ASAP: nsp_clr_next = 1'b1;
            default: nsp_clr_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         plan_reg <= '0;
         plan_valid_reg <= 1'b0;
         last_target_reg <= 32'sh0000_0000;
         nsp_clr_reg <= 1'b0;
         ack_clr_reg <= 1'b0;
      end else begin
         plan_reg <= plan_next;
         plan_valid_reg <= plan_valid_next;
         last_target_reg <= last_target_next;
         nsp_clr_reg <= nsp_clr_next;
         ack_clr_reg <= ack_clr_next;
      end
   end

   assign od_rdata = rdata_reg;
   assign od_ack = ack_reg;
   assign od_err = err_reg;
   assign feed_constant = fc_reg;
   assign feed_done = done_reg;
   assign feed_div_zero = dz_reg;
   assign plan_out = plan_reg;
   assign plan_valid = plan_valid_reg;
   assign clear_new_setpoint = nsp_clr_reg;
   assign clear_setpoint_ack = ack_clr_reg;
   assign opt_word = opt_reg;
endmodule : ppo_options

// ---- logic/ppo_pkg.sv ----
// package: constants and carrier types of the positioning options block
package ppo_pkg;
   // object dictionary entries
   localparam logic [15:0] PPO_IDX_SHAFT_REV = 16'h60EE;
   localparam logic [15:0] PPO_IDX_POS_OPT = 16'h60F2;
   localparam logic [7:0] PPO_SUB_COUNT = 8'h00;
   localparam logic [7:0] PPO_SUB_FIRST = 8'h01;
   // reset values
   localparam logic [7:0] PPO_FEEDBACK_COUNT = 8'h04;
   localparam logic [31:0] PPO_SHAFT_REV_RESET = 32'h0000_0001;
   localparam logic [15:0] PPO_POS_OPT_RESET = 16'h0001;
   // control and status word bit positions
   localparam int PPO_CW_NEW_SETPOINT = 4;
   localparam int PPO_CW_RELATIVE = 6;
   localparam int PPO_SW_SETPOINT_ACK = 12;
   // divider length in cycles
   localparam logic [5:0] PPO_DIV_STEPS = 6'h20;

   typedef enum logic [1:0] {
      REL_PREV_TARGET,
      REL_RAMP_OUTPUT,
      REL_ACTUAL_POS,
      REL_RESERVED
   } ppo_rel_base_t;

   typedef enum logic [1:0] {
      RLS_EXTERNAL,
      RLS_ON_TARGET,
      RLS_ASAP,
      RLS_RESERVED
   } ppo_release_t;

   typedef enum logic [1:0] {
      ROT_LINEAR,
      ROT_NEG_ONLY,
      ROT_POS_ONLY,
      ROT_SHORTEST
   } ppo_rotary_t;

   // option word layout, bit 15 downward
   typedef struct packed {
      logic [7:0] undefined_bits;
      ppo_rotary_t rotary_direction_option;
      ppo_release_t setpoint_release_option;
      logic [1:0] cic_bits;
      ppo_rel_base_t relative_base_select;
   } ppo_opt_t;

   // positions handed in by the trajectory logic
   typedef struct packed {
      logic signed [31:0] target;
      logic signed [31:0] ramp_out;
      logic signed [31:0] actual;
      logic signed [31:0] range_min;
      logic signed [31:0] range_max;
   } ppo_pos_t;

   // move plan handed back to the trajectory logic
   typedef struct packed {
      logic signed [31:0] abs_target;
      logic move_positive;
      logic via_limit;
      logic allow_multi_turn;
   } ppo_plan_t;
endpackage : ppo_pkg

// ---- testbench/ppo_master_model.sv ----
// partner: master side of the new setpoint handshake
`timescale 1ns/100ps
module ppo_master_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic set_req,
   input wire logic drop_req,
   input wire logic rel_move,
   input wire logic clear_new_setpoint,
   input wire logic clear_setpoint_ack,
   output logic [15:0] control_word,
   output logic [15:0] status_word
);
   logic cw_bit4_reg;
   logic sw_bit12_reg;
   always_ff @(posedge core_clk) begin
      if (rst || drop_req) begin
         cw_bit4_reg <= 1'b0;
         sw_bit12_reg <= 1'b0;
      end else begin
         if (set_req)
            cw_bit4_reg <= 1'b1;
         else if (clear_new_setpoint)
            cw_bit4_reg <= 1'b0;
         // drive acknowledges one cycle after the request
         if (clear_setpoint_ack)
            sw_bit12_reg <= 1'b0;
         else if (cw_bit4_reg && !clear_new_setpoint)
            sw_bit12_reg <= 1'b1;
      end
   end
   assign control_word = {9'h000, rel_move, 1'b0, cw_bit4_reg, 4'h0};
   assign status_word = {3'h0, sw_bit12_reg, 12'h000};
endmodule : ppo_master_model

// ---- testbench/ppo_options_props.sv ----
// checker: port timing of the positioning options block
`timescale 1ns/100ps
module ppo_options_props
   import ppo_pkg::*;
#(
   parameter int FEEDBACKS = 4
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic od_wr,
   input wire logic od_rd,
   input wire logic [31:0] od_rdata,
   input wire logic od_ack,
   input wire logic od_err,
   input wire logic [15:0] control_word,
   input wire logic [15:0] status_word,
   input wire logic plan_req,
   input wire ppo_pos_t pos_in,
   input wire logic target_reached,
   input wire ppo_plan_t plan_out,
   input wire logic plan_valid,
   input wire logic clear_new_setpoint,
   input wire logic clear_setpoint_ack,
   input wire ppo_opt_t opt_word
);
   logic rls_cause;
   assign rls_cause = control_word[4] && status_word[12] && (opt_word.setpoint_release_option == RLS_ASAP ||
      (opt_word.setpoint_release_option == RLS_ON_TARGET && target_reached));
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_clear_pair;
      clear_new_setpoint ##1 clear_setpoint_ack;
   endsequence
   // =====
   // access and planning
   chk_one_answer: assert property ((od_wr || od_rd) |=> (od_ack ^ od_err))
      else $error("access not answered once");
   chk_no_answer: assert property (!(od_wr || od_rd) |=> !od_ack && !od_err)
      else $error("answer without access");
   chk_rdata_held: assert property (!od_rd |=> $stable(od_rdata))
      else $error("read data moved without read");
   chk_abs_target: assert property (plan_req && !control_word[6] && pos_in.target >= pos_in.range_min &&
      pos_in.target <= pos_in.range_max |=> plan_valid && plan_out.abs_target == $past(pos_in.target))
      else $error("absolute move target altered");
   chk_linear_multi: assert property (plan_req && opt_word.rotary_direction_option == ROT_LINEAR |=>
      plan_out.allow_multi_turn && !plan_out.via_limit) else $error("linear plan flags wrong");
   chk_neg_only: assert property (plan_req && opt_word.rotary_direction_option == ROT_NEG_ONLY &&
      pos_in.target != pos_in.actual |=> !plan_out.move_positive && !plan_out.allow_multi_turn)
      else $error("negative only mode moved up");
   chk_pos_only: assert property (plan_req && opt_word.rotary_direction_option == ROT_POS_ONLY &&
      pos_in.target != pos_in.actual |=> plan_out.move_positive && !plan_out.allow_multi_turn)
      else $error("positive only mode moved down");
   // =====
   // setpoint release
   chk_clear_pair: assert property (clear_new_setpoint |-> s_clear_pair)
      else $error("ack clear did not follow");
   chk_clear_cause: assert property (clear_new_setpoint |-> $past(rls_cause))
      else $error("setpoint cleared without cause");
   chk_cause_clears: assert property (rls_cause && !clear_new_setpoint |-> ##[1:2] clear_new_setpoint)
      else $error("setpoint not cleared");
endmodule : ppo_options_props

// ---- testbench/profile_position_options_tb.sv ----
// testbench: object access, feed divider, planner and setpoint release
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module profile_position_options_tb;
   import ppo_pkg::*;
   logic core_clk, rst, od_wr, od_rd, od_ack, od_err, feed_start, feed_done, feed_div_zero;
   logic plan_req, plan_valid, target_reached, clr_ns, clr_ack, set_req, drop_req, rel_move;
   logic [15:0] od_index, control_word, status_word;
   logic [7:0] od_subindex;
   logic [31:0] od_wdata, od_rdata, feed_value, feed_constant, rd;
   logic [1:0] feed_sel;
   ppo_pos_t pos_in;
   ppo_plan_t plan_out;
   ppo_opt_t opt_word;
   int n_mismatch = 0;
   int check_count = 0;
   logic [31:0] rel_exp [4] = '{32'd110, 32'd30, 32'd40, 32'd10};
   logic [15:0] rot_opt [5] = '{16'h0000, 16'h0040, 16'h0080, 16'h00C0, 16'h00C0};
   logic [31:0] rot_tgt [5] = '{32'd10, 32'd350, 32'd100, 32'd10, 32'd350};
   logic [31:0] rot_act [5] = '{32'd350, 32'd100, 32'd300, 32'd350, 32'd10};
   logic [2:0] rot_exp [5] = '{3'b001, 3'b010, 3'b110, 3'b110, 3'b010};
   ppo_options #(.FEEDBACKS(4)) dut (.core_clk(core_clk), .rst(rst), .od_wr(od_wr), .od_rd(od_rd),
      .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_rdata(od_rdata),
      .od_ack(od_ack), .od_err(od_err), .feed_start(feed_start), .feed_sel(feed_sel),
      .feed_value(feed_value), .feed_constant(feed_constant), .feed_done(feed_done),
      .feed_div_zero(feed_div_zero), .control_word(control_word), .status_word(status_word),
      .plan_req(plan_req), .pos_in(pos_in), .target_reached(target_reached), .plan_out(plan_out),
      .plan_valid(plan_valid), .clear_new_setpoint(clr_ns), .clear_setpoint_ack(clr_ack),
      .opt_word(opt_word));
   ppo_master_model u_master (.core_clk(core_clk), .rst(rst), .set_req(set_req), .drop_req(drop_req),
      .rel_move(rel_move), .clear_new_setpoint(clr_ns), .clear_setpoint_ack(clr_ack),
      .control_word(control_word), .status_word(status_word));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // =====
   // access tasks
   task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
         input logic [31:0] wd, input logic err);
      @(negedge core_clk);
      od_wr = wr;
      od_rd = !wr;
      od_index = idx;
      od_subindex = sub;
      od_wdata = wd;
      // answer stands for one cycle only, so look before dropping the strobe
      @(negedge core_clk);
      `CHK({od_ack, od_err}, {!err, err})
      rd = od_rdata;
      od_wr = 1'b0;
      od_rd = 1'b0;
   endtask : acc
   task automatic wopt(input logic [15:0] v);
      acc(1'b1, 16'h60F2, 8'h00, {16'h0, v}, 1'b0);
   endtask : wopt
   task automatic feed(input logic [1:0] sel, input logic [31:0] v);
      @(negedge core_clk);
      feed_sel = sel;
      feed_value = v;
      feed_start = 1'b1;
      @(negedge core_clk);
      feed_start = 1'b0;
      // pulse lasts one cycle, so stop advancing once it shows
      repeat (40) if (feed_done !== 1'b1) @(negedge core_clk);
      `CHK(feed_done, 1'b1)
   endtask : feed
   task automatic plan(input logic [31:0] tgt, input logic [31:0] act);
      @(negedge core_clk);
      pos_in.target = tgt;
      pos_in.actual = act;
      plan_req = 1'b1;
      // valid is a one-cycle pulse; plan_out then holds until the next request
      @(negedge core_clk);
      `CHK(plan_valid, 1'b1)
      plan_req = 1'b0;
   endtask : plan
   task automatic tally_and_finish;
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // =====
   // tests
   initial begin
      {rst, od_wr, od_rd, feed_start, plan_req, target_reached, set_req, drop_req, rel_move} = 9'h100;
      {od_index, od_subindex, od_wdata, feed_value, feed_sel} = '0;
      pos_in = '{target: 0, ramp_out: 20, actual: 0, range_min: 0, range_max: 359};
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      acc(1'b0, 16'h60EE, 8'h00, 32'h0, 1'b0);
      `CHK(rd, 32'h0000_0004)
      for (int i = 1; i <= 4; i++) begin
         acc(1'b0, 16'h60EE, i[7:0], 32'h0, 1'b0);
         `CHK(rd, 32'h0000_0001)
      end
      acc(1'b0, 16'h60F2, 8'h00, 32'h0, 1'b0);
      `CHK({rd, opt_word}, {32'h0000_0001, 16'h0001})
      acc(1'b1, 16'h60EE, 8'h00, 32'h9, 1'b1);
      acc(1'b0, 16'h60EE, 8'h00, 32'h0, 1'b0);
      `CHK(rd, 32'h0000_0004)
      acc(1'b0, 16'h60F3, 8'h00, 32'h0, 1'b1);
      acc(1'b1, 16'h60F2, 8'h00, 32'hFFFF_A5C1, 1'b0);
      acc(1'b0, 16'h60F2, 8'h00, 32'h0, 1'b0);
      `CHK(rd, 32'h0000_A5C1)
      acc(1'b1, 16'h60EE, 8'h02, 32'h7, 1'b0);
      feed(2'd1, 32'd100);
      `CHK(feed_constant, 32'd14)
      acc(1'b1, 16'h60EE, 8'h03, 32'h0, 1'b0);
      feed(2'd2, 32'd5);
      `CHK({feed_div_zero, feed_constant}, {1'b1, 32'hFFFF_FFFF})
      feed(2'd0, 32'd9);
      `CHK({feed_div_zero, feed_constant}, {1'b0, 32'd9})
      wopt(16'h0000);
      plan(32'd100, 32'd30);
      `CHK(plan_out.abs_target, 32'd100)
      rel_move = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wopt({14'h0, i[1:0]});
         plan(32'd10, 32'd30);
         `CHK(plan_out.abs_target, rel_exp[i])
      end
      rel_move = 1'b0;
      for (int i = 0; i < 5; i++) begin
         wopt(rot_opt[i]);
         plan(rot_tgt[i], rot_act[i]);
         `CHK({plan_out.move_positive, plan_out.via_limit, plan_out.allow_multi_turn}, rot_exp[i])
      end
      for (int m = 0; m < 4; m++) begin
         wopt({10'h0, m[1:0], 4'h0});
         target_reached = 1'b0;
         set_req = 1'b1;
         @(negedge core_clk);
         set_req = 1'b0;
         repeat (6) @(negedge core_clk);
         `CHK({control_word[4], status_word[12]}, {2{m != 2}})
         target_reached = 1'b1;
         repeat (6) @(negedge core_clk);
         `CHK({control_word[4], status_word[12]}, {2{m == 0 || m == 3}})
         drop_req = 1'b1;
         @(negedge core_clk);
         drop_req = 1'b0;
      end
      tally_and_finish();
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule : profile_position_options_tb
bind ppo_options ppo_options_props #(.FEEDBACKS(FEEDBACKS)) u_props (.core_clk(core_clk), .rst(rst),
   .od_wr(od_wr), .od_rd(od_rd), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
   .control_word(control_word), .status_word(status_word), .plan_req(plan_req), .pos_in(pos_in),
   .target_reached(target_reached), .plan_out(plan_out), .plan_valid(plan_valid),
   .clear_new_setpoint(clear_new_setpoint), .clear_setpoint_ack(clear_setpoint_ack), .opt_word(opt_word));
